// ===== hw/sysconf_pkg.sv
// Constants and types shared by the configuration register and the external master end
package sysconf_pkg;
   localparam int unsigned CLK_MHZ = 25;
   localparam logic [31:0] MCR_RESET = 32'h00007CFF;
   localparam logic [31:0] MCR_WMASK = 32'hE001FFFF;
   localparam int unsigned COMP_LVL_HI = 31;
   localparam int unsigned COMP_LVL_LO = 29;
   localparam int unsigned BUS_SYNC_TIMING_SEL_BIT = 16;
   localparam int unsigned ARB_SYNC_TIMING_SEL_BIT = 15;
   localparam int unsigned FRZT_BIT = 14;
   localparam int unsigned FRZB_BIT = 13;
   localparam int unsigned BCO_LVL_HI = 12;
   localparam int unsigned BCO_LVL_LO = 10;
   localparam int unsigned SHOW_HI = 9;
   localparam int unsigned SHOW_LO = 8;
   localparam int unsigned SUPERVISOR_RESTRICT_BIT = 7;
   localparam int unsigned BCI_HI = 6;
   localparam int unsigned BCI_LO = 4;
   localparam int unsigned IARB_HI = 3;
   localparam int unsigned IARB_LO = 0;
   localparam logic [1:0] SHOW_NONE = 2'h0;
   localparam logic [1:0] SHOW_NOARB = 2'h1;
   localparam logic [2:0] LVL_FORBIDDEN = 3'h7;
   localparam logic [2:0] LVL_SUGGEST = 3'h3;
   localparam logic [3:0] FC_SUPERVISOR_RESTRICT_DATA = 4'h5;
   typedef logic [2:0] level_t;
   typedef enum logic [1:0]
   {
      M_IDLE = 2'b00,
      M_REQ = 2'b01,
      M_OWN = 2'b11,
      M_REL = 2'b10
   } master_state_t;
endpackage : sysconf_pkg

// ===== hw/sysbus_if.sv
// Interface joining the configuration end and the external master end
`timescale 1ns/1ps
`default_nettype none
interface sysbus_if;
   logic br_n;
   logic bus_grant_ack_n;
   logic as_n;
   logic ds_n;
   logic bg_n;
   logic bclr_out_n;
   logic bclr_in_n;
   logic comp_br_n;
   modport dev (input br_n, input bus_grant_ack_n, input as_n, input ds_n, input bclr_in_n,
      input comp_br_n, output bg_n, output bclr_out_n);
   modport ext (output br_n, output bus_grant_ack_n, output as_n, output ds_n, output bclr_in_n,
      output comp_br_n, input bg_n, input bclr_out_n);
endinterface : sysbus_if
`default_nettype wire

// ===== hw/sysconf_dev.sv
// Module configuration register and the bus control logic it steers
`timescale 1ns/1ps
`default_nettype none
module sysconf_dev
   import sysconf_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   // Register port
   input wire logic REG_WR_I,
   input wire logic [31:0] REG_WDATA_I,
   output logic [31:0] REG_RDATA_O,
   // Mode and internal state
   input wire logic SLAVE_MODE_I,
   input wire logic COMPANION_MODE_I,
   input wire logic FREEZE_I,
   input wire logic INT_REQ_I,
   input wire sysconf_pkg::level_t INT_ARB_LEVEL_I,
   input wire sysconf_pkg::level_t INT_SERVICE_LEVEL_I,
   input wire logic INT_ACCESS_I,
   input wire logic INT_ACC_EXT_I,
   input wire logic FAST_TERM_I,
   // Internal bus side outputs
   output logic COMP_REQ_O,
   output sysconf_pkg::level_t COMP_REQ_LEVEL_O,
   output logic TIMERS_RUN_O,
   output logic BUSMON_EN_O,
   output logic INT_HALT_O,
   output logic EXT_STROBE_O,
   output logic SHOW_DRIVE_O,
   output logic ADDR_REFLECT_O,
   output logic EXT_TERM_SHOW_O,
   output logic SUPERVISOR_RESTRICT_RESTRICT_O,
   // External bus side
   sysbus_if.dev bus
);
   import sysconf_pkg::*;

   logic [31:0] mcr_r;
   logic [2:0] as_s_r;
   logic [2:0] ds_s_r;
   logic [2:0] br_s_r;
   logic [2:0] bus_grant_ack_s_r;
   logic [2:0] bci_s_r;
   logic [2:0] cbr_s_r;
   logic bg_n_r;
   logic bclr_out_n_r;
   logic comp_req_r;
   logic halt_r;
   logic strobe_r;
   logic drive_r;
   logic refl_r;
   logic timers_r;
   logic busmon_r;
   logic term_r;
   level_t comp_lvl_r;
   logic br_cur;
   logic bus_grant_ack_cur;
   logic as_cur;
   logic ds_cur;
   logic [1:0] show_eff;
   logic arb_en;
   logic bg_nxt;
   logic bclr_nxt;
   logic halt_nxt;
   logic strobe_nxt;
   logic drive_nxt;
   logic refl_nxt;

   // Three-stage sampling; only stages two and three are looked at
   always_ff @(posedge SYS_CLK_I)
   begin
      as_s_r <= {as_s_r[1:0], bus.as_n};
      ds_s_r <= {ds_s_r[1:0], bus.ds_n};
      br_s_r <= {br_s_r[1:0], bus.br_n};
      bus_grant_ack_s_r <= {bus_grant_ack_s_r[1:0], bus.bus_grant_ack_n};
      bci_s_r <= {bci_s_r[1:0], bus.bclr_in_n};
      cbr_s_r <= {cbr_s_r[1:0], bus.comp_br_n};
   end

   // Synchronised value changes only once stages two and three agree
   logic as_q;
   logic ds_q;
   logic br_q;
   logic bus_grant_ack_q;
   logic bci_q;
   logic cbr_q;
   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         as_q <= 1'b1;
         ds_q <= 1'b1;
         br_q <= 1'b1;
         bus_grant_ack_q <= 1'b1;
         bci_q <= 1'b1;
         cbr_q <= 1'b1;
      end
      else
      begin
         if (as_s_r[1] == as_s_r[2]) as_q <= as_s_r[2];
         if (ds_s_r[1] == ds_s_r[2]) ds_q <= ds_s_r[2];
         if (br_s_r[1] == br_s_r[2]) br_q <= br_s_r[2];
         if (bus_grant_ack_s_r[1] == bus_grant_ack_s_r[2]) bus_grant_ack_q <= bus_grant_ack_s_r[2];
         if (bci_s_r[1] == bci_s_r[2]) bci_q <= bci_s_r[2];
         if (cbr_s_r[1] == cbr_s_r[2]) cbr_q <= cbr_s_r[2];
      end
   end

   // Raw pins are only legal when the master meets setup and hold
   assign as_cur = mcr_r[BUS_SYNC_TIMING_SEL_BIT] ? bus.as_n : as_q;
   assign ds_cur = mcr_r[BUS_SYNC_TIMING_SEL_BIT] ? bus.ds_n : ds_q;
   assign br_cur = mcr_r[ARB_SYNC_TIMING_SEL_BIT] ? bus.br_n : br_q;
   assign bus_grant_ack_cur = mcr_r[ARB_SYNC_TIMING_SEL_BIT] ? bus.bus_grant_ack_n : bus_grant_ack_q;

   // Slave mode keeps the stored field but runs as if it were zero
   assign show_eff = SLAVE_MODE_I ? SHOW_NONE : mcr_r[SHOW_HI:SHOW_LO];
   assign arb_en = (show_eff != SHOW_NOARB);
   // Grant never given with arbitration off; requests simply ignored
   assign bg_nxt = !(arb_en && !br_cur && !INT_REQ_I) && !(arb_en && !bus_grant_ack_cur);
   assign bclr_nxt = !((INT_REQ_I &&
      INT_ARB_LEVEL_I > mcr_r[BCO_LVL_HI:BCO_LVL_LO])
      || (!SLAVE_MODE_I && INT_SERVICE_LEVEL_I > mcr_r[BCI_HI:BCI_LO]));
   // Show strobe yields while an external master runs its own strobe cycle
   assign strobe_nxt = (show_eff != SHOW_NONE) && INT_ACCESS_I && as_cur;
   assign drive_nxt = (show_eff != SHOW_NONE) && INT_ACCESS_I;
   assign refl_nxt = (show_eff == SHOW_NONE) && INT_ACCESS_I && ds_cur;
   // Halt holds until both request and acknowledge have negated
   assign halt_nxt = show_eff[1] && (!br_cur || !bus_grant_ack_cur);

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
         mcr_r <= MCR_RESET;
      else if (REG_WR_I)
         mcr_r <= REG_WDATA_I & MCR_WMASK;
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         bg_n_r <= 1'b1;
         bclr_out_n_r <= 1'b1;
         comp_req_r <= 1'b0;
         comp_lvl_r <= '0;
         halt_r <= 1'b0;
         strobe_r <= 1'b0;
         drive_r <= 1'b0;
         refl_r <= 1'b0;
         timers_r <= 1'b1;
         busmon_r <= 1'b1;
         term_r <= 1'b0;
         REG_RDATA_O <= MCR_RESET;
      end
      else
      begin
         bg_n_r <= bg_nxt;
         bclr_out_n_r <= bclr_nxt;
         comp_req_r <= COMPANION_MODE_I && !cbr_q;
         comp_lvl_r <= COMPANION_MODE_I ? mcr_r[COMP_LVL_HI:COMP_LVL_LO] : '0;
         halt_r <= halt_nxt;
         strobe_r <= strobe_nxt;
         drive_r <= drive_nxt;
         refl_r <= refl_nxt;
         timers_r <= !(FREEZE_I && mcr_r[FRZT_BIT]);
         busmon_r <= !(FREEZE_I && mcr_r[FRZB_BIT]);
         term_r <= INT_ACC_EXT_I && !FAST_TERM_I;
         REG_RDATA_O <= REG_WR_I ? (REG_WDATA_I & MCR_WMASK) : mcr_r;
      end
   end

   assign bus.bg_n = bg_n_r;
   assign bus.bclr_out_n = bclr_out_n_r;
   assign COMP_REQ_O = comp_req_r;
   assign COMP_REQ_LEVEL_O = comp_lvl_r;
   assign INT_HALT_O = halt_r;
   assign EXT_STROBE_O = strobe_r;
   assign SHOW_DRIVE_O = drive_r;
   assign ADDR_REFLECT_O = refl_r;
   assign TIMERS_RUN_O = timers_r;
   assign BUSMON_EN_O = busmon_r;
   assign EXT_TERM_SHOW_O = term_r;
   assign SUPERVISOR_RESTRICT_RESTRICT_O = mcr_r[SUPERVISOR_RESTRICT_BIT];
endmodule : sysconf_dev
`default_nettype wire

// ===== hw/sysconf_ext.sv
// External master end: arbitrates for the bus and runs strobe cycles
`timescale 1ns/1ps
`default_nettype none
module sysconf_ext
   import sysconf_pkg::*;
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   // User side
   input wire logic XFER_REQ_I,
   input wire logic ARB_DISABLED_I,
   input wire logic COMP_REQ_I,
   input wire logic BCLR_IN_I,
   output logic XFER_DONE_O,
   output logic OWNS_BUS_O,
   output logic CLEAR_SEEN_O,
   // Bus side
   sysbus_if.ext bus
);
   import sysconf_pkg::*;

   master_state_t st_r, st_nxt;
   logic done_r, clr_r, cbr_r, bci_r;
   logic [2:0] bg_s_r, bco_s_r;
   logic bg_q, bco_q;

   always_ff @(posedge SYS_CLK_I)
   begin
      bg_s_r <= {bg_s_r[1:0], bus.bg_n};
      bco_s_r <= {bco_s_r[1:0], bus.bclr_out_n};
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         bg_q <= 1'b1;
         bco_q <= 1'b1;
      end
      else
      begin
         if (bg_s_r[1] == bg_s_r[2]) bg_q <= bg_s_r[2];
         if (bco_s_r[1] == bco_s_r[2]) bco_q <= bco_s_r[2];
      end
   end

   // Requests are withheld while arbitration is off
   always_comb
   begin
      st_nxt = st_r;
      case (st_r)
         M_IDLE: if (XFER_REQ_I && !ARB_DISABLED_I) st_nxt = M_REQ;
         M_REQ: if (!bg_q) st_nxt = M_OWN;
         M_OWN: st_nxt = M_REL;
         M_REL: st_nxt = M_IDLE;
         default: st_nxt = M_IDLE;
      endcase
   end

   always_ff @(posedge SYS_CLK_I)
   begin
      if (SYS_RST_I)
      begin
         st_r <= M_IDLE;
         done_r <= 1'b0;
         clr_r <= 1'b0;
         cbr_r <= 1'b1;
         bci_r <= 1'b1;
      end
      else
      begin
         st_r <= st_nxt;
         done_r <= (st_r == M_OWN);
         clr_r <= !bco_q;
         cbr_r <= !COMP_REQ_I;
         bci_r <= !BCLR_IN_I;
      end
   end

   assign bus.br_n = !(st_r == M_REQ);
   assign bus.bus_grant_ack_n = !(st_r == M_OWN);
   assign bus.as_n = !(st_r == M_OWN);
   assign bus.ds_n = !(st_r == M_OWN);
   assign bus.comp_br_n = cbr_r;
   assign bus.bclr_in_n = bci_r;
   assign XFER_DONE_O = done_r;
   assign OWNS_BUS_O = st_r[1];
   assign CLEAR_SEEN_O = clr_r;
endmodule : sysconf_ext
`default_nettype wire

// ===== testbench/sysconf_sva.sv
// Checker on the pins between the configuration end and the external master end
`timescale 1ns/1ps
`default_nettype none
module sysconf_sva
(
   // Clock and reset
   input wire logic SYS_CLK_I,
   input wire logic SYS_RST_I,
   // Bus pins
   input wire logic br_n,
   input wire logic bus_grant_ack_n,
   input wire logic as_n,
   input wire logic ds_n,
   input wire logic bg_n,
   input wire logic bclr_out_n,
   input wire logic bclr_in_n,
   input wire logic comp_br_n
);
   default clocking cb @(posedge SYS_CLK_I);
   endclocking
   default disable iff (SYS_RST_I);
   // Reset is synchronous, so the first edge after release shows the reset state
   a_rst_dev_idle: assert property ($fell(SYS_RST_I) |-> bg_n && bclr_out_n)
      else $error("device pins not idle after reset");
   a_rst_ext_idle: assert property ($fell(SYS_RST_I) |-> br_n && bus_grant_ack_n && as_n && ds_n)
      else $error("master pins not idle after reset");
   a_grant_after_req: assert property ($fell(bg_n) |-> !$past(br_n))
      else $error("grant without request");
   a_req_held: assert property ($fell(br_n) |=> !br_n)
      else $error("request shorter than two cycles");
   a_as_needs_own: assert property (!as_n |-> !bus_grant_ack_n)
      else $error("address strobe without ownership");
   a_ds_needs_own: assert property (!ds_n |-> !bus_grant_ack_n)
      else $error("data strobe without ownership");
   a_ack_after_grant: assert property ($fell(bus_grant_ack_n) |-> !$past(bg_n))
      else $error("acknowledge without grant");
   a_release_clean: assert property ($rose(bus_grant_ack_n) |-> as_n && ds_n)
      else $error("strobes held past release");
   c_grant: cover property ($fell(bg_n));
   c_clear: cover property ($fell(bclr_out_n));
   c_strobe: cover property ($fell(as_n));
endmodule : sysconf_sva
`default_nettype wire

// ===== testbench/system_module_config_register_bench.sv
// Bench joining both ends through the bus interface
`timescale 1ns/1ps
`default_nettype none
module system_module_config_register_bench;
   import sysconf_pkg::*;
   logic SYS_CLK_I = 1'b0, SYS_RST_I = 1'b1, REG_WR_I = 1'b0, SLAVE_MODE_I = 1'b0;
   logic COMPANION_MODE_I = 1'b0, FREEZE_I = 1'b0, INT_REQ_I = 1'b0, INT_ACCESS_I = 1'b0;
   logic INT_ACC_EXT_I = 1'b0, FAST_TERM_I = 1'b0, XFER_REQ_I = 1'b0, ARB_DISABLED_I = 1'b0;
   logic COMP_REQ_I = 1'b0, BCLR_IN_I = 1'b0, hseen = 1'b0;
   logic [31:0] REG_WDATA_I = 32'h0;
   level_t INT_ARB_LEVEL_I = 3'h0, INT_SERVICE_LEVEL_I = 3'h0, COMP_REQ_LEVEL_O;
   logic [31:0] REG_RDATA_O;
   logic COMP_REQ_O, TIMERS_RUN_O, BUSMON_EN_O, INT_HALT_O, EXT_STROBE_O, SHOW_DRIVE_O;
   logic ADDR_REFLECT_O, EXT_TERM_SHOW_O, SUPERVISOR_RESTRICT_RESTRICT_O, XFER_DONE_O, OWNS_BUS_O, CLEAR_SEEN_O;
   int mismatches = 0, n_tests = 0, l0, l1;
   sysbus_if bus ();
   always #20 SYS_CLK_I = ~SYS_CLK_I;
   sysconf_dev i_sysconf_dev (.SYS_CLK_I, .SYS_RST_I, .REG_WR_I, .REG_WDATA_I, .REG_RDATA_O,
      .SLAVE_MODE_I, .COMPANION_MODE_I, .FREEZE_I, .INT_REQ_I, .INT_ARB_LEVEL_I,
      .INT_SERVICE_LEVEL_I, .INT_ACCESS_I, .INT_ACC_EXT_I, .FAST_TERM_I, .COMP_REQ_O,
      .COMP_REQ_LEVEL_O, .TIMERS_RUN_O, .BUSMON_EN_O, .INT_HALT_O, .EXT_STROBE_O,
      .SHOW_DRIVE_O, .ADDR_REFLECT_O, .EXT_TERM_SHOW_O, .SUPERVISOR_RESTRICT_RESTRICT_O, .bus(bus));
   sysconf_ext i_sysconf_ext (.SYS_CLK_I, .SYS_RST_I, .XFER_REQ_I, .ARB_DISABLED_I,
      .COMP_REQ_I, .BCLR_IN_I, .XFER_DONE_O, .OWNS_BUS_O, .CLEAR_SEEN_O, .bus(bus));
   sysconf_sva i_sysconf_sva (.SYS_CLK_I, .SYS_RST_I, .br_n(bus.br_n), .bus_grant_ack_n(bus.bus_grant_ack_n),
      .as_n(bus.as_n), .ds_n(bus.ds_n), .bg_n(bus.bg_n), .bclr_out_n(bus.bclr_out_n),
      .bclr_in_n(bus.bclr_in_n), .comp_br_n(bus.comp_br_n));
   task summarize;
      $display("tests %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task cyc(input int n);
      repeat (n) @(negedge SYS_CLK_I);
   endtask : cyc
   // Read data lands on the write edge itself
   task wr(input logic [31:0] v);
      cyc(1);
      REG_WR_I = 1'b1;
      REG_WDATA_I = v;
      cyc(1);
      REG_WR_I = 1'b0;
      cyc(1);
   endtask : wr
   // Pins cross synchronisers, so the wait is bounded rather than fixed
   task xfer(output int lat);
      XFER_REQ_I = 1'b1;
      lat = 0;
      while (XFER_DONE_O !== 1'b1 && lat < 60)
      begin
         cyc(1);
         lat++;
         if (OWNS_BUS_O === 1'b1 && INT_HALT_O === 1'b1)
            hseen = 1'b1;
      end
      XFER_REQ_I = 1'b0;
      cyc(8);
   endtask : xfer
   task t_regs;
      chk("reset", MCR_RESET, REG_RDATA_O);
      chk("supervisor_restrict", 32'h1, SUPERVISOR_RESTRICT_RESTRICT_O);
      wr(32'h7FFFFF7F);
      wr(32'h5FFEFF7F);
      chk("rdata", 32'h5FFEFF7F & MCR_WMASK, REG_RDATA_O);
      chk("supervisor_restrict", 32'h0, SUPERVISOR_RESTRICT_RESTRICT_O);
   endtask : t_regs
   task t_comp;
      wr(32'h60007CFF);
      COMPANION_MODE_I = 1'b1;
      COMP_REQ_I = 1'b1;
      cyc(8);
      chk("clvl", 32'h3, COMP_REQ_LEVEL_O);
      chk("creq", 32'h1, COMP_REQ_O);
      COMPANION_MODE_I = 1'b0;
      COMP_REQ_I = 1'b0;
      cyc(8);
      chk("clvl", 32'h0, COMP_REQ_LEVEL_O);
   endtask : t_comp
   task t_freeze;
      FREEZE_I = 1'b1;
      wr(MCR_RESET);
      chk("timers", 32'h0, TIMERS_RUN_O);
      chk("busmon", 32'h0, BUSMON_EN_O);
      wr(MCR_RESET & 32'hFFFF9FFF);
      chk("timers", 32'h1, TIMERS_RUN_O);
      chk("busmon", 32'h1, BUSMON_EN_O);
      FREEZE_I = 1'b0;
   endtask : t_freeze
   task t_arb;
      wr(MCR_RESET);
      xfer(l0);
      wr(MCR_RESET | 32'h00018000);
      xfer(l1);
      chk("synclat", 32'h1, l0 > l1);
      chk("done", 32'h1, l1 < 60);
      wr(MCR_RESET | 32'h00000100);
      XFER_REQ_I = 1'b1;
      cyc(30);
      chk("owns", 32'h0, OWNS_BUS_O);
      chk("bg", 32'h1, bus.bg_n);
      wr(MCR_RESET);
      xfer(l0);
      chk("late", 32'h1, l0 < 60);
      ARB_DISABLED_I = 1'b1;
      XFER_REQ_I = 1'b1;
      cyc(20);
      chk("br", 32'h1, bus.br_n);
      XFER_REQ_I = 1'b0;
      ARB_DISABLED_I = 1'b0;
      cyc(40);
   endtask : t_arb
   task t_show;
      wr(MCR_RESET | 32'h00000200);
      INT_ACCESS_I = 1'b1;
      xfer(l0);
      chk("halt", 32'h1, hseen);
      chk("resume", 32'h0, INT_HALT_O);
      chk("drive", 32'h1, SHOW_DRIVE_O);
      chk("stb", 32'h1, EXT_STROBE_O);
      INT_ACC_EXT_I = 1'b1;
      FAST_TERM_I = 1'b1;
      cyc(2);
      chk("tshow", 32'h0, EXT_TERM_SHOW_O);
      SLAVE_MODE_I = 1'b1;
      cyc(2);
      chk("slvdrive", 32'h0, SHOW_DRIVE_O);
      SLAVE_MODE_I = 1'b0;
      INT_ACC_EXT_I = 1'b0;
      FAST_TERM_I = 1'b0;
      wr(MCR_RESET);
      cyc(2);
      chk("drive", 32'h0, SHOW_DRIVE_O);
      chk("stb", 32'h0, EXT_STROBE_O);
      chk("reflect", 32'h1, ADDR_REFLECT_O);
      INT_ACCESS_I = 1'b0;
   endtask : t_show
   task t_clear;
      wr(32'h00006CFF);
      INT_REQ_I = 1'b1;
      INT_ARB_LEVEL_I = 3'h4;
      cyc(8);
      chk("bclr", 32'h0, bus.bclr_out_n);
      chk("seen", 32'h1, CLEAR_SEEN_O);
      INT_ARB_LEVEL_I = 3'h3;
      cyc(4);
      chk("bclr", 32'h1, bus.bclr_out_n);
      INT_REQ_I = 1'b0;
      wr(32'h00006CAF);
      INT_SERVICE_LEVEL_I = 3'h3;
      cyc(4);
      chk("bclr", 32'h0, bus.bclr_out_n);
      INT_SERVICE_LEVEL_I = 3'h2;
      cyc(4);
      chk("bclr", 32'h1, bus.bclr_out_n);
   endtask : t_clear
   initial
   begin
      cyc(4);
      SYS_RST_I = 1'b0;
      cyc(1);
      t_regs();
      t_comp();
      t_freeze();
      t_arb();
      t_show();
      t_clear();
      summarize();
   end
   // Whole run is a few hundred cycles; this cuts a hang short
   initial
   begin
      #2000000;
      mismatches++;
      summarize();
   end
endmodule : system_module_config_register_bench
`default_nettype wire
